// File: core/crr_ctrl.v
/*
 core reset sequencer and regulator control register
 assumes: an analog power-on detector, cpu special function register port,
 sleep/suspend requests from the power unit, one 50 mhz system clock
*/
// Summary of operation
// - regulator off in sleep, on in suspend
// - bias bit forces oscillator bias on outside sleep
// - unused and reserved bits read zero
// - reset halts cpu, defaults registers, disables
// - reset keeps ram, reinitialises stack pointer
// - port latches ones, open drain, pull-ups
// - reset pin low for power resets
// - exit restores pc and internal oscillator
// - watchdog runs on clock divided by twelve
// - fetch starts at address zero
// - power-on adds supply dependent release delay
// - power-on exit sets cause flag
// - resets other than power-on and power-fail clear the cause flag
// - data memory undefined after power-on
// - mode bit five disables battery monitor
// - monitor disabled: any reset is full
// - power-fail reset sets flag, enables monitor
`timescale 1ns/1ps
`include "crr_regs.vh"
module crr_ctrl #(
	parameter DLY_LOW_CYC  = `CRR_DLY_LOW_MS * 1000 * `CRR_CLK_MHZ,
	parameter DLY_MID_CYC  = `CRR_DLY_MID_MS * 1000 * `CRR_CLK_MHZ,
	parameter DLY_HIGH_CYC = `CRR_DLY_HIGH_MS * 1000 * `CRR_CLK_MHZ
) (
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_n,
	// reset sources
	input  wire        por_ok,
	input  wire [1:0]  supply_level,
	input  wire        power_fail_req,
	input  wire        other_reset_req,
	// power mode requests
	input  wire        sleep_mode,
	input  wire        suspend_mode,
	// special function register port
	input  wire        sfr_wr,
	input  wire        sfr_rd,
	input  wire [7:0]  sfr_addr,
	input  wire [7:0]  sfr_wdata,
	input  wire        pmode_wr,
	input  wire [7:0]  pmode_wdata,
	output reg  [7:0]  sfr_rdata,
	// cpu and system outputs
	output reg         cpu_halt,
	output reg         sfr_defaults,
	output reg  [15:0] pc_init,
	output reg         stack_reinit,
	output reg         ram_undefined,
	output reg         clk_sel_internal,
	output reg         wdt_enable,
	output reg         wdt_tick,
	output reg         irq_timer_disable,
	// ports
	output reg  [7:0]  port_latch,
	output reg         port_open_drain,
	output reg         port_weak_pullup,
	// reset pin, open drain
	output reg         rst_pin_out,
	output reg         rst_pin_oe,
	// regulator and monitors
	output reg         core_supply_regulator,
	output reg         precision_osc_bias_force,
	output reg         battery_monitor_disable,
	output reg         supply_monitor_enable,
	output reg         power_on_cause_flag
);
	// sequencer states
	localparam ST_HOLD  = 2'h0;
	localparam ST_DELAY = 2'h1;
	localparam ST_RUN   = 2'h2;

	// delay counter width
	localparam CW = 24;

	// reset delay chosen from supply level
	function [CW-1:0] por_delay;
		input [1:0] lvl;
		begin
			case (lvl)
				2'h0:    por_delay = DLY_LOW_CYC[CW-1:0];
				2'h1:    por_delay = DLY_MID_CYC[CW-1:0];
				default: por_delay = DLY_HIGH_CYC[CW-1:0];
			endcase
		end
	endfunction

	// pin inputs pass three flops
	reg [2:0] por_s_reg;
	reg [2:0] pf_s_reg;
	reg [2:0] oth_s_reg;
	reg       por_hold_reg; // last level on which flops two and three agreed
	reg       pf_hold_reg;  // same for power-fail request
	reg       oth_hold_reg; // same for other reset request
	wire      por_good  = por_hold_reg;
	wire      pf_act    = pf_hold_reg;
	wire      oth_act   = oth_hold_reg;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_s_reg <= 3'h0;
			pf_s_reg  <= 3'h0;
			oth_s_reg <= 3'h0;
			por_hold_reg <= 1'b0;
			pf_hold_reg  <= 1'b0;
			oth_hold_reg <= 1'b0;
		end else begin
			por_s_reg <= {por_s_reg[1:0], por_ok};
			pf_s_reg  <= {pf_s_reg[1:0], power_fail_req};
			oth_s_reg <= {oth_s_reg[1:0], other_reset_req};
			por_hold_reg <= (por_s_reg[2] == por_s_reg[1]) ? por_s_reg[2] : por_hold_reg;
			pf_hold_reg  <= (pf_s_reg[2] == pf_s_reg[1]) ? pf_s_reg[2] : pf_hold_reg;
			oth_hold_reg <= (oth_s_reg[2] == oth_s_reg[1]) ? oth_s_reg[2] : oth_hold_reg;
		end
	end

	// combined raw reset request
	reg  battery_monitor_disable_reg;
	wire raw_rst_n = rst_n & por_ok;

	// synchronised power reset
	wire por_srst_n;
	crr_rst_sync u_sync (
		.core_clk (core_clk),
		.arst_n   (raw_rst_n),
		.srst_n   (por_srst_n)
	);

	// sequencer registers
	reg [1:0]    state_reg;
	reg [1:0]    state_next;
	reg [CW-1:0] cnt_reg;
	reg [CW-1:0] cnt_next;
	reg          full_reg;   // current reset is power-on kind
	reg          full_next;
	reg          pwr_reg;    // drive reset pin
	reg          pwr_next;
	reg [3:0]    div_reg;    // watchdog divider
	reg          bias_reg;

	// full power-on sequence when monitor disabled
	wire full_req = (oth_act | pf_act) & battery_monitor_disable_reg;

	// next state logic
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		full_next  = full_reg;
		pwr_next   = pwr_reg;
		case (state_reg)
			ST_HOLD: begin
				// a supply fail seen while held also pulls the pin
				if (pf_act) begin
					pwr_next = 1'b1;
				end
				// wait for supply above threshold
				if (por_good && !pf_act && !oth_act) begin
					if (full_reg) begin
						state_next = ST_DELAY;
						cnt_next   = por_delay(supply_level);
					end else begin
						state_next = ST_RUN;
						pwr_next   = 1'b0;
					end
				end
			end
			ST_DELAY: begin
				// release delay after power-on
				if (!por_good) begin
					state_next = ST_HOLD;
				end else if (cnt_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
					state_next = ST_RUN;
					pwr_next   = 1'b0;
				end else begin
					cnt_next = cnt_reg - {{(CW-1){1'b0}}, 1'b1};
				end
			end
			ST_RUN: begin
				// new reset request enters hold
				if (full_req) begin
					state_next = ST_HOLD;
					full_next  = 1'b1;
					pwr_next   = 1'b1;
				end else if (pf_act) begin
					state_next = ST_HOLD;
					full_next  = 1'b0;
					pwr_next   = 1'b1;
				end else if (oth_act) begin
					state_next = ST_HOLD;
					full_next  = 1'b0;
					pwr_next   = 1'b0;
				end
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase
	end

	// sequencer state and cause flag
	always @(posedge core_clk or negedge por_srst_n) begin
		if (!por_srst_n) begin
			state_reg           <= ST_HOLD;
			cnt_reg             <= {CW{1'b0}};
			full_reg            <= 1'b1;
			pwr_reg             <= 1'b1;
			power_on_cause_flag <= 1'b0;
			ram_undefined       <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			full_reg  <= full_next;
			pwr_reg   <= pwr_next;
			if (state_reg != ST_RUN && state_next == ST_RUN) begin
				// set on power-on or power-fail exit, else clear
				power_on_cause_flag <= full_reg | pf_act | pwr_reg;
				ram_undefined       <= full_reg;
			end
		end
	end

	// in-reset level shared by outputs
	wire in_reset = (state_next != ST_RUN);

	// cpu, port and pin outputs
	always @(posedge core_clk or negedge por_srst_n) begin
		if (!por_srst_n) begin
			cpu_halt          <= 1'b1;
			sfr_defaults      <= 1'b1;
			irq_timer_disable <= 1'b1;
			stack_reinit      <= 1'b1;
			pc_init           <= `CRR_PC_RESET;
			clk_sel_internal  <= 1'b1;
			port_latch        <= `CRR_PORT_RESET;
			port_open_drain   <= 1'b1;
			port_weak_pullup  <= 1'b1;
			rst_pin_out       <= 1'b0;
			rst_pin_oe        <= 1'b1;
		end else begin
			cpu_halt          <= in_reset;
			sfr_defaults      <= in_reset;
			irq_timer_disable <= in_reset;
			stack_reinit      <= in_reset;
			pc_init           <= `CRR_PC_RESET;
			if (in_reset) begin
				clk_sel_internal <= 1'b1;
				port_latch       <= `CRR_PORT_RESET;
				port_open_drain  <= 1'b1;
			end
			port_weak_pullup <= 1'b1;
			rst_pin_out      <= 1'b0;
			rst_pin_oe       <= in_reset & pwr_next;
		end
	end

	// last divider count before a tick
	localparam integer WDT_LAST_I = `CRR_WDT_DIV - 1;
	wire [3:0] wdt_last = WDT_LAST_I[3:0];

	// watchdog enabled with divide-by-twelve tick
	always @(posedge core_clk or negedge por_srst_n) begin
		if (!por_srst_n) begin
			div_reg    <= 4'h0;
			wdt_tick   <= 1'b0;
			wdt_enable <= 1'b0;
		end else if (in_reset) begin
			div_reg    <= 4'h0;
			wdt_tick   <= 1'b0;
			wdt_enable <= 1'b0;
		end else begin
			wdt_enable <= 1'b1;
			wdt_tick   <= (div_reg == wdt_last);
			div_reg    <= (div_reg == wdt_last) ? 4'h0 : div_reg + 4'h1;
		end
	end

	// register writes: bias bit and monitor disable
	wire regctl_wr = sfr_wr && (sfr_addr == `CRR_REGCTL_ADDR) && !in_reset;
	always @(posedge core_clk or negedge por_srst_n) begin
		if (!por_srst_n) begin
			bias_reg   <= 1'b1;
			battery_monitor_disable_reg <= 1'b0;
		end else begin
			if (in_reset && !(state_reg == ST_RUN)) begin
				bias_reg <= 1'b1;
				if (full_reg) begin
					battery_monitor_disable_reg <= 1'b0;
				end
			end else begin
				if (regctl_wr) begin
					bias_reg <= sfr_wdata[`CRR_REGCTL_BIAS_BIT];
				end
				if (pmode_wr) begin
					battery_monitor_disable_reg <= pmode_wdata[`CRR_PMODE_BATTERY_MONITOR_DISABLE_BIT];
				end
			end
		end
	end

	// read data and regulator outputs
	always @(posedge core_clk or negedge por_srst_n) begin
		if (!por_srst_n) begin
			sfr_rdata                <= 8'h00;
			core_supply_regulator    <= 1'b1;
			precision_osc_bias_force <= 1'b1;
			battery_monitor_disable  <= 1'b0;
			supply_monitor_enable    <= 1'b1;
		end else begin
			if (sfr_rd && sfr_addr == `CRR_REGCTL_ADDR) begin
				sfr_rdata <= {3'h0, bias_reg, 4'h0} & `CRR_REGCTL_WMASK;
			end else begin
				sfr_rdata <= 8'h00;
			end
			core_supply_regulator    <= !sleep_mode || suspend_mode;
			precision_osc_bias_force <= bias_reg && !sleep_mode;
			battery_monitor_disable  <= battery_monitor_disable_reg;
			if (in_reset && (full_reg || pf_act)) begin
				supply_monitor_enable <= 1'b1;
			end
		end
	end
endmodule // crr_ctrl

// File: core/crr_regs.vh
/*
 register map, field positions, reset values and timing counts for the
 core reset and regulator controller; assumes a 50 mhz system clock
*/
`ifndef CRR_REGS_VH
`define CRR_REGS_VH
`define CRR_REGCTL_ADDR      8'hc9
`define CRR_REGCTL_RESET     8'h10
`define CRR_REGCTL_BIAS_BIT  4
`define CRR_REGCTL_WMASK     8'h10
`define CRR_CAUSE_POR_BIT    1
`define CRR_PMODE_BATTERY_MONITOR_DISABLE_BIT 5
`define CRR_PORT_RESET       8'hff
`define CRR_PC_RESET         16'h0000
`define CRR_WDT_DIV          12
`define CRR_CLK_MHZ          50
`define CRR_DLY_LOW_MS       3
`define CRR_DLY_MID_MS       7
`define CRR_DLY_HIGH_MS      15
`define CRR_BIAS_SETTLE_US   4
`endif

// File: core/crr_rst_sync.v
/*
 reset synchroniser: asserts asynchronously, releases after three clean
 clock edges; assumes arst_n may come from any source
*/
`timescale 1ns/1ps
module crr_rst_sync (
	// clock and raw reset
	input  wire core_clk,
	input  wire arst_n,
	// synchronised reset
	output wire srst_n
);
	reg [2:0] sync_reg; // release shift chain

	// shift ones in after release
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], 1'b1};
		end
	end

	assign srst_n = sync_reg[2];
endmodule // crr_rst_sync

// File: tb/core_reset_and_regulator_ctrl_tb.sv
/*
 self-checking bench for the reset and regulator controller
 assumes: crr_ctrl with short delay counts, 50 mhz clock
*/
`timescale 1ns/1ps
module core_reset_and_regulator_ctrl_tb;
	// stimulus
	reg         core_clk, rst_n, por_ok, power_fail_req, other_reset_req;
	reg         sleep_mode, suspend_mode, sfr_wr, sfr_rd, pmode_wr;
	reg  [1:0]  supply_level;
	reg  [7:0]  sfr_addr, sfr_wdata, pmode_wdata, q, d;
	// observed
	wire [7:0]  sfr_rdata, port_latch;
	wire [15:0] pc_init;
	wire        cpu_halt, sfr_defaults, stack_reinit, ram_undefined, clk_sel_internal;
	wire        wdt_enable, wdt_tick, irq_timer_disable, port_open_drain, port_weak_pullup;
	wire        rst_pin_out, rst_pin_oe, core_supply_regulator, precision_osc_bias_force;
	wire        battery_monitor_disable, supply_monitor_enable, power_on_cause_flag;
	integer     n_errors, n_tests, i, n;
	crr_ctrl #(.DLY_LOW_CYC(20), .DLY_MID_CYC(40), .DLY_HIGH_CYC(60)) dut (
		.core_clk                 (core_clk),
		.rst_n                    (rst_n),
		.por_ok                   (por_ok),
		.supply_level             (supply_level),
		.power_fail_req           (power_fail_req),
		.other_reset_req          (other_reset_req),
		.sleep_mode               (sleep_mode),
		.suspend_mode             (suspend_mode),
		.sfr_wr                   (sfr_wr),
		.sfr_rd                   (sfr_rd),
		.sfr_addr                 (sfr_addr),
		.sfr_wdata                (sfr_wdata),
		.pmode_wr                 (pmode_wr),
		.pmode_wdata              (pmode_wdata),
		.sfr_rdata                (sfr_rdata),
		.cpu_halt                 (cpu_halt),
		.sfr_defaults             (sfr_defaults),
		.pc_init                  (pc_init),
		.stack_reinit             (stack_reinit),
		.ram_undefined            (ram_undefined),
		.clk_sel_internal         (clk_sel_internal),
		.wdt_enable               (wdt_enable),
		.wdt_tick                 (wdt_tick),
		.irq_timer_disable        (irq_timer_disable),
		.port_latch               (port_latch),
		.port_open_drain          (port_open_drain),
		.port_weak_pullup         (port_weak_pullup),
		.rst_pin_out              (rst_pin_out),
		.rst_pin_oe               (rst_pin_oe),
		.core_supply_regulator    (core_supply_regulator),
		.precision_osc_bias_force (precision_osc_bias_force),
		.battery_monitor_disable  (battery_monitor_disable),
		.supply_monitor_enable    (supply_monitor_enable),
		.power_on_cause_flag      (power_on_cause_flag)
	);
	// free running clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// falling edge pacing
	task steps(input integer k); repeat (k) @(negedge core_clk); endtask
	// compare and count
	task chk(input [15:0] seen, input [15:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// register write strobe
	task wr(input [7:0] a, input [7:0] v);
		sfr_addr = a;
		sfr_wdata = v;
		sfr_wr = 1'b1;
		steps(1);
		sfr_wr = 1'b0;
	endtask
	// register read, data one cycle later
	task rd(input [7:0] a);
		sfr_addr = a;
		sfr_rd = 1'b1;
		steps(1);
		sfr_rd = 1'b0;
		q = sfr_rdata;
	endtask
	// cycles until the cpu runs
	task wait_run;
		n = 0;
		while (cpu_halt !== 1'b0 && n < 3000) begin
			steps(1);
			n = n + 1;
		end
		chk(cpu_halt, 1'b0);
	endtask
	// release delay per supply level
	function integer dly(input integer lv); dly = (lv > 1) ? 60 : 20 * (lv + 1); endfunction
	// verdict
	task report_and_stop;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// hang guard
	initial begin
		#400000;
		n_errors = n_errors + 1;
		report_and_stop;
	end
	// main sequence
	initial begin
		{rst_n, por_ok, power_fail_req, other_reset_req, sleep_mode, suspend_mode} = 6'h00;
		{sfr_wr, sfr_rd, pmode_wr, supply_level} = 5'h00;
		{sfr_addr, sfr_wdata, pmode_wdata} = 24'h000000;
		n_errors = 0;
		n_tests = 0;
		void'($urandom(12));
		steps(20);
		rst_n = 1'b1;
		// power-on for every supply level
		for (i = 0; i < 4; i = i + 1) begin
			por_ok = 1'b0;
			steps(2);
			chk({cpu_halt, rst_pin_oe, port_latch}, 10'h3ff);
			supply_level = i;
			por_ok = 1'b1;
			wait_run;
			chk(n >= dly(i) && n <= dly(i) + 12, 1'b1);
			chk({power_on_cause_flag, ram_undefined, wdt_enable, clk_sel_internal,
				supply_monitor_enable, battery_monitor_disable}, 6'h3e);
			rd(8'hc9);
			chk(q, 8'h10);
		end
		// random and corner register writes
		for (i = 0; i < 16; i = i + 1) begin
			d = ((i == 0) ? 8'hef : (i == 1) ? 8'hff : 8'($urandom)) & 8'h9e;
			wr(8'hc9, d);
			rd(8'hc9);
			chk(q, d & 8'h10);
			steps(2);
			chk(precision_osc_bias_force, d[4]);
			rd(8'($urandom % 201));
			chk(q, 8'h00);
		end
		// sleep and suspend
		wr(8'hc9, 8'h10);
		steps(200);
		sleep_mode = 1'b1;
		steps(3);
		chk({core_supply_regulator, precision_osc_bias_force}, 2'b00);
		suspend_mode = 1'b1;
		steps(3);
		chk(core_supply_regulator, 1'b1);
		{sleep_mode, suspend_mode} = 2'b00;
		steps(3);
		chk(precision_osc_bias_force, 1'b1);
		// plain reset clears cause flag
		wr(8'hc9, 8'h00);
		other_reset_req = 1'b1;
		steps(8);
		chk({cpu_halt, rst_pin_oe}, 2'b10);
		other_reset_req = 1'b0;
		wait_run;
		chk({power_on_cause_flag, ram_undefined}, 2'b00);
		rd(8'hc9);
		chk(q, 8'h10);
		// supply fail reset, no release delay
		power_fail_req = 1'b1;
		steps(8);
		chk({cpu_halt, rst_pin_oe}, 2'b11);
		power_fail_req = 1'b0;
		wait_run;
		chk(n <= 10, 1'b1);
		chk({power_on_cause_flag, supply_monitor_enable}, 2'b11);
		// monitor disabled turns any reset into full sequence
		pmode_wdata = 8'h20;
		pmode_wr = 1'b1;
		steps(1);
		pmode_wr = 1'b0;
		steps(2);
		chk(battery_monitor_disable, 1'b1);
		other_reset_req = 1'b1;
		steps(8);
		other_reset_req = 1'b0;
		wait_run;
		chk(n >= 40, 1'b1);
		chk({power_on_cause_flag, battery_monitor_disable}, 2'b10);
		// watchdog tick spacing
		for (n = 0; n < 40 && wdt_tick !== 1'b1; n = n + 1)
			steps(1);
		steps(1);
		for (n = 1; n < 40 && wdt_tick !== 1'b1; n = n + 1)
			steps(1);
		chk(n[15:0], 16'd12);
		steps(30);
		report_and_stop;
	end
endmodule // core_reset_and_regulator_ctrl_tb

// File: tb/crr_ctrl_checker.sv
/*
 port relations of the reset and regulator controller
 assumes: bound to crr_ctrl, one clock domain
*/
`timescale 1ns/1ps
module crr_ctrl_checker (
	// clock, reset, inputs
	input wire        core_clk,
	input wire        rst_n,
	input wire        sleep_mode,
	input wire        suspend_mode,
	input wire        power_fail_req,
	input wire        sfr_wr,
	input wire        sfr_rd,
	input wire [7:0]  sfr_addr,
	input wire [7:0]  sfr_wdata,
	// outputs watched
	input wire [7:0]  sfr_rdata,
	input wire        cpu_halt,
	input wire        sfr_defaults,
	input wire [15:0] pc_init,
	input wire        stack_reinit,
	input wire        wdt_tick,
	input wire        irq_timer_disable,
	input wire [7:0]  port_latch,
	input wire        port_open_drain,
	input wire        port_weak_pullup,
	input wire        rst_pin_out,
	input wire        rst_pin_oe,
	input wire        core_supply_regulator,
	input wire        precision_osc_bias_force
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// pin only ever pulled low
	property p_pin; rst_pin_oe |-> !rst_pin_out; endproperty
	a_pin: assert property (p_pin) else $error("reset pin driven high");
	// ports parked while halted
	property p_port; cpu_halt |-> port_latch == 8'hff && port_open_drain && port_weak_pullup;
	endproperty
	a_port: assert property (p_port) else $error("port state wrong in reset");
	// cpu side held in reset
	property p_halt; cpu_halt |-> sfr_defaults && irq_timer_disable && stack_reinit;
	endproperty
	a_halt: assert property (p_halt) else $error("reset defaults missing");
	// fetch origin
	property p_pc; pc_init == 16'h0000; endproperty
	a_pc: assert property (p_pc) else $error("fetch origin not zero");
	// regulator off in sleep
	property p_sleep; sleep_mode && !suspend_mode && !cpu_halt |=> !core_supply_regulator;
	endproperty
	a_sleep: assert property (p_sleep) else $error("regulator on in sleep");
	// regulator kept in suspend
	property p_susp; suspend_mode && !cpu_halt |=> core_supply_regulator; endproperty
	a_susp: assert property (p_susp) else $error("regulator off in suspend");
	// bias follows written bit
	property p_bias; sfr_wr && sfr_addr == 8'hc9 && !cpu_halt
		##1 (!sfr_wr && !sleep_mode && !cpu_halt) [*2]
		|=> precision_osc_bias_force == $past(sfr_wdata[4], 3); endproperty
	a_bias: assert property (p_bias) else $error("bias does not follow write");
	// only bias bit readable
	property p_rd; sfr_rd |=> (sfr_rdata & ($past(sfr_addr) == 8'hc9 ? 8'hef : 8'hff)) == 8'h00;
	endproperty
	a_rd: assert property (p_rd) else $error("unused bits read nonzero");
	// supply fail drives pin
	property p_pf; power_fail_req [*6] |-> rst_pin_oe; endproperty
	a_pf: assert property (p_pf) else $error("pin not driven on supply fail");
	// watchdog tick spacing
	property p_wdt; wdt_tick |=> (!wdt_tick) [*8]; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog ticks too close");
	// main scenarios
	c_pin: cover property (rst_pin_oe ##1 !rst_pin_oe);
	c_wdt: cover property (wdt_tick);
	c_susp: cover property (sleep_mode && suspend_mode);
endmodule // crr_ctrl_checker

bind crr_ctrl crr_ctrl_checker chk (.core_clk, .rst_n, .sleep_mode, .suspend_mode,
	.power_fail_req, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata, .sfr_rdata, .cpu_halt,
	.sfr_defaults, .pc_init, .stack_reinit, .wdt_tick, .irq_timer_disable, .port_latch,
	.port_open_drain, .port_weak_pullup, .rst_pin_out, .rst_pin_oe, .core_supply_regulator,
	.precision_osc_bias_force);
